// ---- verilog/operand_address_mode_unit.sv ----
// Functional notes
// - Low three specifier bits pick the register, upper three the mode, mode bit 0 means deferred.
// - Mode 0 uses the register itself as the operand with no memory access.
// - Byte operations on a register operand touch only its low byte.
// - Mode 2 uses the register as address then steps it by 1 for bytes, 2 for words, 2 for SP and PC.
// - Mode 4 first decreases the register by 2 or 1 and then uses it as address.
// - Mode 6 fetches the next instruction-stream word and adds it to the register.
// - Indexed forms never write back the index word, and leave the register unchanged unless it is the PC, which steps past the index word.
// - Mode 1 uses the register as the operand address unchanged.
// - Mode 3 reads a pointer at the register address and then adds two to it.
// - Mode 5 subtracts two from the register then reads the pointer there.
// - Mode 7 reads the pointer at register plus index word, leaving both unchanged unless the register is the PC.
// - Registers 6 and 7 are stack pointer and program counter yet take every mode.
// - With two indexed operands the source index word is taken first, then the destination.
// - Mode 2 word access completes before the register write-back.
`timescale 1ns/1ps
`default_nettype none
`include "opaddr_params.svh"
module operand_address_mode_unit
   import opaddr_pkg::*;
#(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // request from the instruction sequencer
   input  wire logic         start,
   input  wire logic [5:0]   spec,
   input  wire logic         byte_op,
   input  wire logic         do_write,
   input  wire logic [W-1:0] wr_operand,
   output logic              busy,
   output logic              done,
   output logic [W-1:0]      operand_r,
   output logic [W-1:0]      oper_addr_r,
   // memory port
   output logic              mem_req,
   output logic              mem_we,
   output logic              mem_byte,
   output logic [W-1:0]      mem_addr_r,
   output logic [W-1:0]      mem_wdata_r,
   input  wire logic         mem_ack,
   input  wire logic [W-1:0] mem_rdata
);
   agen_state_t  state_r;
   addr_mode_t   mode_r;
   logic [2:0]   sel_r;
   logic         byte_r;
   logic         wr_r;
   logic [W-1:0] wop_r;
   logic [W-1:0] wb_val_r;
   logic         wb_pend_r;
   logic [W-1:0] rd_data;
   logic [W-1:0] pc_data;
   logic         rf_we;
   logic         rf_low;
   logic [2:0]   rf_sel;
   logic [W-1:0] rf_wdata;

   // step width for the autoincrement and autodecrement forms
   function automatic logic [W-1:0] step_of(input addr_mode_t m, input logic b,
                                            input logic [2:0] r);
      // SP and PC step by two
      if (m == MODE_AINC_DEF || m == MODE_ADEC_DEF || !b || r == `SP_INDEX
          || r == `PC_INDEX) begin
         step_of = `STEP_WORD;
      end else begin
         step_of = `STEP_BYTE;
      end
   endfunction

   function automatic logic is_indexed(input addr_mode_t m);
      is_indexed = (m == MODE_IDX) || (m == MODE_IDX_DEF);
   endfunction

   reg_file #(.W(W)) u_regs (
      .clk         (clk),
      .rst_n       (rst_n),
      .rd_sel      (sel_r),
      .rd_data     (rd_data),
      .pc_sel      (`PC_INDEX),
      .pc_data     (pc_data),
      .wr_en       (rf_we),
      .wr_low_only (rf_low),
      .wr_sel      (rf_sel),
      .wr_data     (rf_wdata)
   );

   assign busy     = (state_r != ST_IDLE);
   assign done     = (state_r == ST_DONE);
   assign mem_req  = (state_r == ST_IDX) || (state_r == ST_PTR) || (state_r == ST_OPRD)
                     || (state_r == ST_OPWR);
   assign mem_we   = (state_r == ST_OPWR);
   // pointer and index fetches are always words
   assign mem_byte = byte_r && ((state_r == ST_OPRD) || (state_r == ST_OPWR));

   // register file write arbitration
   always_comb begin
      rf_we    = 1'b0;
      rf_low   = 1'b0;
      rf_sel   = sel_r;
      rf_wdata = wb_val_r;
      if (state_r == ST_IDX && mem_ack) begin
         rf_we    = 1'b1;
         rf_sel   = `PC_INDEX;
         rf_wdata = W'(pc_data + `STEP_WORD);
      end else if (state_r == ST_DECODE && mode_r == MODE_REG && wr_r) begin
         rf_we    = 1'b1;
         rf_low   = byte_r;
         rf_wdata = wop_r;
      end else if (state_r == ST_WB && wb_pend_r) begin
         rf_we = 1'b1;
      end
   end

   // sequencing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               if (mode_r == MODE_REG) begin
                  state_r <= ST_DONE;
               end else if (is_indexed(mode_r)) begin
                  state_r <= ST_IDX;
               end else if (mode_r[0] && mode_r != MODE_REG_DEF) begin
                  state_r <= ST_PTR;
               end else begin
                  state_r <= wr_r ? ST_OPWR : ST_OPRD;
               end
            end
            ST_IDX: begin
               if (mem_ack) begin
                  state_r <= (mode_r == MODE_IDX_DEF) ? ST_PTR : (wr_r ? ST_OPWR : ST_OPRD);
               end
            end
            ST_PTR: begin
               if (mem_ack) begin
                  state_r <= wr_r ? ST_OPWR : ST_OPRD;
               end
            end
            ST_OPRD, ST_OPWR: begin
               if (mem_ack) begin
                  state_r <= ST_WB;
               end
            end
            ST_WB: begin
               state_r <= ST_DONE;
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // request capture and decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= MODE_REG;
         sel_r  <= 3'h0;
         byte_r <= 1'b0;
         wr_r   <= 1'b0;
         wop_r  <= `WORD_RESET;
      end else if (state_r == ST_IDLE && start) begin
         mode_r <= addr_mode_t'(spec[`MODE_FIELD_MSB:`MODE_FIELD_LSB]);
         sel_r  <= spec[`REG_FIELD_MSB:`REG_FIELD_LSB];
         byte_r <= byte_op;
         wr_r   <= do_write;
         wop_r  <= wr_operand;
      end
   end

   // address formation and side effects
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr_r  <= `WORD_RESET;
         mem_wdata_r <= `WORD_RESET;
         oper_addr_r <= `WORD_RESET;
         operand_r   <= `WORD_RESET;
         wb_val_r    <= `WORD_RESET;
         wb_pend_r   <= 1'b0;
      end else begin
         unique case (state_r)
            ST_DECODE: begin
               mem_wdata_r <= wop_r;
               wb_pend_r   <= 1'b0;
               unique case (mode_r)
                  MODE_REG: begin
                     operand_r <= byte_r ? {{(W-8){1'b0}}, rd_data[`LOW_BYTE_MSB:0]} : rd_data;
                  end
                  MODE_REG_DEF: begin
                     mem_addr_r  <= rd_data;
                     oper_addr_r <= rd_data;
                  end
                  MODE_AINC, MODE_AINC_DEF: begin
                     mem_addr_r  <= rd_data;
                     oper_addr_r <= rd_data;
                     wb_val_r    <= W'(rd_data + step_of(mode_r, byte_r, sel_r));
                     wb_pend_r   <= 1'b1;
                  end
                  MODE_ADEC, MODE_ADEC_DEF: begin
                     mem_addr_r  <= W'(rd_data - step_of(mode_r, byte_r, sel_r));
                     oper_addr_r <= W'(rd_data - step_of(mode_r, byte_r, sel_r));
                     wb_val_r    <= W'(rd_data - step_of(mode_r, byte_r, sel_r));
                     wb_pend_r   <= 1'b1;
                  end
                  MODE_IDX, MODE_IDX_DEF: begin
                     // index word read at PC, in call order
                     mem_addr_r <= pc_data;
                  end
               endcase
            end
            ST_IDX: begin
               if (mem_ack) begin
                  mem_addr_r  <= W'(mem_rdata + rd_data);
                  oper_addr_r <= W'(mem_rdata + rd_data);
               end
            end
            ST_PTR: begin
               if (mem_ack) begin
                  mem_addr_r  <= mem_rdata;
                  oper_addr_r <= mem_rdata;
               end
            end
            ST_OPRD: begin
               if (mem_ack) begin
                  operand_r <= byte_r ? {{(W-8){1'b0}}, mem_rdata[`LOW_BYTE_MSB:0]} : mem_rdata;
               end
            end
            ST_WB: begin
               wb_pend_r <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- verilog/opaddr_params.svh ----
`ifndef OPADDR_PARAMS_SVH
`define OPADDR_PARAMS_SVH
`define REG_FIELD_LSB   0
`define REG_FIELD_MSB   2
`define MODE_FIELD_LSB  3
`define MODE_FIELD_MSB  5
`define SP_INDEX        3'h6
`define PC_INDEX        3'h7
`define STEP_BYTE       16'h0001
`define STEP_WORD       16'h0002
`define WORD_RESET      16'h0000
`define LOW_BYTE_MSB    7
`endif

// ---- verilog/opaddr_pkg.sv ----
`default_nettype none
package opaddr_pkg;
   typedef enum logic [2:0] {
      MODE_REG      = 3'h0,
      MODE_REG_DEF  = 3'h1,
      MODE_AINC     = 3'h2,
      MODE_AINC_DEF = 3'h3,
      MODE_ADEC     = 3'h4,
      MODE_ADEC_DEF = 3'h5,
      MODE_IDX      = 3'h6,
      MODE_IDX_DEF  = 3'h7
   } addr_mode_t;
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_DECODE = 8'h02,
      ST_IDX   = 8'h04,
      ST_PTR   = 8'h08,
      ST_OPRD  = 8'h10,
      ST_OPWR  = 8'h20,
      ST_WB    = 8'h40,
      ST_DONE  = 8'h80
   } agen_state_t;
endpackage
`default_nettype wire

// ---- verilog/reg_file.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "opaddr_params.svh"
module reg_file #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // read ports
   input  wire logic [2:0]   rd_sel,
   output logic      [W-1:0] rd_data,
   input  wire logic [2:0]   pc_sel,
   output logic      [W-1:0] pc_data,
   // write port with byte lane control
   input  wire logic         wr_en,
   input  wire logic         wr_low_only,
   input  wire logic [2:0]   wr_sel,
   input  wire logic [W-1:0] wr_data
);
   logic [W-1:0] regs_r [8];

   assign rd_data = regs_r[rd_sel];
   assign pc_data = regs_r[pc_sel];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_reg
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               regs_r[g] <= `WORD_RESET;
            end else if (wr_en && wr_sel == 3'(g)) begin
               if (wr_low_only) begin
                  regs_r[g][`LOW_BYTE_MSB:0] <= wr_data[`LOW_BYTE_MSB:0];
               end else begin
                  regs_r[g] <= wr_data;
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- tb/opaddr_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module opaddr_chk #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic         clk,
   input wire logic         rst_n,
   // sequencer side
   input wire logic         start,
   input wire logic [5:0]   spec,
   input wire logic         busy,
   input wire logic         done,
   // memory side
   input wire logic         mem_req,
   input wire logic         mem_we,
   input wire logic         mem_byte,
   input wire logic [W-1:0] mem_addr_r,
   input wire logic         mem_ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_done_pulse: assert property (done |=> !done)
      else $error("done held longer than one cycle");
   a_done_idle: assert property (done |-> busy ##1 !busy)
      else $error("unit not idle after done");
   a_busy_start: assert property (start && !busy |=> busy)
      else $error("start not taken while idle");
   a_idle_quiet: assert property (!busy |-> !mem_req)
      else $error("memory request while idle");
   a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr_r))
      else $error("memory request changed before acknowledge");
   a_reg_fast: assert property (start && !busy && spec[5:3] == 3'h0 |=> !mem_req ##1 (done && !mem_req))
      else $error("register mode not done in two cycles");
   a_ptr_access: assert property (start && !busy && spec[5:3] == 3'h1 |=> !mem_req ##1 mem_req)
      else $error("register deferred mode did not access memory");
   a_idx_word: assert property (start && !busy && spec[5:4] == 2'h3 |=> ##1 (mem_req && !mem_we && !mem_byte))
      else $error("index fetch not a word read");
   a_done_bound: assert property (start && !busy |-> ##[2:60] done)
      else $error("evaluation did not finish");
endmodule
bind operand_address_mode_unit opaddr_chk #(.W(W)) chk_inst (.clk(clk), .rst_n(rst_n),
   .start(start), .spec(spec), .busy(busy), .done(done), .mem_req(mem_req), .mem_we(mem_we),
   .mem_byte(mem_byte), .mem_addr_r(mem_addr_r), .mem_ack(mem_ack));
`default_nettype wire

// ---- tb/mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // memory port
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [15:0] mem_addr_r,
   input wire logic [15:0] mem_wdata_r,
   input wire logic [1:0]  lat,
   output logic            mem_ack,
   output logic [15:0]     mem_rdata,
   // last write seen
   output logic [15:0]     last_wa,
   output logic [15:0]     last_wd
);
   logic [1:0] cnt;
   // contents are the inverse of the address; idle data toggles so stale reads show
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h0000;
         cnt <= 2'h0;
         last_wa <= 16'h0000;
         last_wd <= 16'h0000;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            if (cnt == lat) begin
               mem_ack <= 1'b1;
               mem_rdata <= ~mem_addr_r;
               cnt <= 2'h0;
               if (mem_we) begin
                  last_wa <= mem_addr_r;
                  last_wd <= mem_wdata_r;
               end
            end else begin
               cnt <= cnt + 2'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/operand_address_mode_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module operand_address_mode_unit_tb;
   logic        clk, rst_n, start, byte_op, do_write, busy, done;
   logic        mem_req, mem_we, mem_byte, mem_ack;
   logic [5:0]  spec;
   logic [1:0]  lat;
   logic [15:0] wr_operand, operand_r, oper_addr_r, mem_addr_r, mem_wdata_r;
   logic [15:0] mem_rdata, last_wa, last_wd;
   int          failures, n_tests;
   operand_address_mode_unit operand_address_mode_unit_inst (.clk(clk), .rst_n(rst_n),
      .start(start), .spec(spec), .byte_op(byte_op), .do_write(do_write),
      .wr_operand(wr_operand), .busy(busy), .done(done), .operand_r(operand_r),
      .oper_addr_r(oper_addr_r), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
      .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   mem_model mem_model_inst (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .lat(lat), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .last_wa(last_wa), .last_wd(last_wd));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one evaluation; waits for done under a bound
   task op(input logic [5:0] s, input logic b, input logic w, input logic [15:0] d);
      int i;
      @(negedge clk);
      start = 1'b1;
      spec = s;
      byte_op = b;
      do_write = w;
      wr_operand = d;
      @(negedge clk);
      start = 1'b0;
      for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge clk);
      chk({15'h0000, done}, 16'h0001);
   endtask
   task creg(input logic [2:0] r, input logic [15:0] exp);
      op({3'h0, r}, 1'b0, 1'b0, 16'h0000);
      chk(operand_r, exp);
   endtask
   task cadr(input logic [5:0] s, input logic b, input logic [15:0] exp);
      op(s, b, 1'b0, 16'h0000);
      chk(oper_addr_r, exp);
   endtask
   task sc_reg;
      op(6'h01, 1'b0, 1'b1, 16'h1234);
      op(6'h01, 1'b1, 1'b1, 16'h00AB);
      creg(3'h1, 16'h12AB);
      op(6'h01, 1'b1, 1'b0, 16'h0000);
      chk(operand_r, 16'h00AB);
   endtask
   task sc_ainc;
      op(6'h02, 1'b0, 1'b1, 16'h1000);
      op(6'h12, 1'b0, 1'b1, 16'h5555);
      chk(last_wa, 16'h1000);
      chk(last_wd, 16'h5555);
      cadr(6'h0A, 1'b0, 16'h1002);
      chk(operand_r, 16'hEFFD);
      cadr(6'h12, 1'b1, 16'h1002);
      creg(3'h2, 16'h1003);
   endtask
   task sc_step;
      op(6'h06, 1'b0, 1'b1, 16'h2000);
      op(6'h16, 1'b1, 1'b0, 16'h0000);
      creg(3'h6, 16'h2002);
      cadr(6'h26, 1'b1, 16'h2000);
      op(6'h03, 1'b0, 1'b1, 16'h3000);
      cadr(6'h23, 1'b1, 16'h2FFF);
      cadr(6'h23, 1'b0, 16'h2FFD);
   endtask
   task sc_def;
      op(6'h04, 1'b0, 1'b1, 16'h4000);
      cadr(6'h1C, 1'b1, 16'hBFFF);
      creg(3'h4, 16'h4002);
      cadr(6'h2C, 1'b1, 16'hBFFF);
      creg(3'h4, 16'h4000);
   endtask
   task sc_idx;
      // base register for the indexed forms; set to 1000 here, replacing the byte-test value
      op(6'h01, 1'b0, 1'b1, 16'h1000);
      op(6'h07, 1'b0, 1'b1, 16'h0100);
      op(6'h05, 1'b0, 1'b1, 16'h0020);
      cadr(6'h31, 1'b0, 16'h0EFF);
      creg(3'h7, 16'h0102);
      creg(3'h1, 16'h1000);
      cadr(6'h39, 1'b0, 16'hF102);
      creg(3'h1, 16'h1000);
      cadr(6'h31, 1'b0, 16'h0EFB);
      op(6'h35, 1'b0, 1'b1, 16'h7777);
      chk(last_wa, 16'hFF19);
      chk(last_wd, 16'h7777);
   endtask
   task wrap_up;
      $display("mismatches %0d, comparisons %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      spec = 6'h00;
      byte_op = 1'b0;
      do_write = 1'b0;
      wr_operand = 16'h0000;
      lat = 2'h0;
      failures = 0;
      n_tests = 0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      sc_reg;
      sc_ainc;
      sc_step;
      // slow memory for the deferred and indexed forms
      lat = 2'h2;
      sc_def;
      sc_idx;
      wrap_up;
   end
   // roughly 30 evaluations of under 20 cycles each; generous margin
   initial begin
      #(25 * 5000);
      failures++;
      wrap_up;
   end
endmodule
`default_nettype wire
